// ### common/ifd_pkg.sv
// constants and types shared by the instruction field decoder
// What this block does
// - take each instruction as one 14-bit word
// - sort words into byte, bit, literal groups
// - d=0 writes accumulator, d=1 writes file
// - file address spans 0x00 to 0x7f
// - bit select touches one bit only
// - literal is eight or eleven bits wide
// - every cycle lasts four oscillator periods
// - true skip or branch adds a nop cycle
// - named file is read before it is stored
// - don't-care bits ignored, either value accepted
// - port read-modify-write uses pin levels
package ifd_pkg;
  // ==========================================
  // widths
  localparam int INSTR_W           = 14;
  localparam int FA_W              = 7;
  localparam int BS_W              = 3;
  localparam int LIT_W             = 11;
  localparam int DATA_W            = 8;
  localparam int PERIODS_PER_CYCLE = 4;
  // ==========================================
  // field positions
  localparam int POS_GRP_HI  = 13;
  localparam int POS_GRP_LO  = 12;
  localparam int POS_OP_HI   = 11;
  localparam int POS_OP_LO   = 8;
  localparam int POS_DEST    = 7;
  localparam int POS_BS_HI   = 9;
  localparam int POS_BS_LO   = 7;
  localparam int POS_FA_HI   = 6;
  localparam int POS_BITTEST = 11;
  localparam int POS_BITSET  = 10;
  // ==========================================
  // group and opcode codes
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT  = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;
  localparam logic [3:0] OP_CTRL  = 4'h0;
  localparam logic [3:0] OP_CLR   = 4'h1;
  localparam logic [3:0] OP_DECSZ = 4'hb;
  localparam logic [3:0] OP_INCSZ = 4'hf;
  localparam logic [1:0] LOP_RET  = 2'h1;
  localparam logic [7:0] CTL_RET  = 8'h08;
  localparam logic [7:0] CTL_RETI = 8'h09;
  localparam logic [7:0] CTL_SLP  = 8'h63;
  localparam logic [7:0] CTL_WDT  = 8'h64;
  // ==========================================
  // reset values
  localparam logic [INSTR_W-1:0] INSTR_RST = 14'h0000;
  localparam logic [DATA_W-1:0]  DATA_RST  = 8'h00;
  typedef enum logic [1:0] {CLS_BYTE, CLS_BIT, CLS_LIT} ifd_class_t;
endpackage

// ### logic/ifd_phase_gen.sv
// oscillator period counter giving one-hot phase enables per instruction cycle
`timescale 1ns/1ps
module ifd_phase_gen
  import ifd_pkg::*;
#(
  parameter int PERIODS = PERIODS_PER_CYCLE
) (
  input  wire logic               clock,
  input  wire logic               nrst,
  output logic      [PERIODS-1:0] phase_en
);
  initial begin
    if (PERIODS < 4) $error("ifd_phase_gen needs at least four phases");
  end

  logic [PERIODS-1:0] phase_reg;
  logic [PERIODS-1:0] phase_next;

  // ==========================================
  // rotating one-hot phase
  always_comb begin
    phase_next = {phase_reg[PERIODS-2:0], phase_reg[PERIODS-1]};
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      phase_reg <= {{(PERIODS-1){1'b0}}, 1'b1};
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase_en = phase_reg;
endmodule

// ### logic/ifd_decoder.sv
// instruction field decoder and cycle sequencer with read-modify-write strobes
`timescale 1ns/1ps
module ifd_decoder
  import ifd_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic [INSTR_W-1:0]   instr_word,
  input  wire logic                 cond_true,
  input  wire logic                 addr_is_port,
  input  wire logic [DATA_W-1:0]    file_rd_data,
  input  wire logic [DATA_W-1:0]    port_pins,
  output logic                      fetch_req,
  output logic      [INSTR_W-1:0]   instr_reg,
  output ifd_class_t                class_reg,
  output logic      [3:0]           op_reg,
  output logic      [FA_W-1:0]      file_addr_reg,
  output logic                      dest_reg,
  output logic      [BS_W-1:0]      bit_sel_reg,
  output logic      [LIT_W-1:0]     literal_reg,
  output logic                      nop_cycle_reg,
  output logic                      file_rd,
  output logic                      file_wr,
  output logic                      w_wr,
  output logic                      sleep_req,
  output logic                      wdt_clear,
  output logic      [DATA_W-1:0]    rmw_data_reg
);
  logic [PERIODS_PER_CYCLE-1:0] phase_en;

  ifd_phase_gen #(
    .PERIODS (PERIODS_PER_CYCLE)
  ) u_phase (
    .clock    (clock),
    .nrst     (nrst),
    .phase_en (phase_en)
  );

  logic q2;
  logic q4;
  assign q2 = phase_en[1];
  assign q4 = phase_en[PERIODS_PER_CYCLE-1];

  // ==========================================
  // decode helpers
  function automatic logic f_names_file(input logic [INSTR_W-1:0] w);
    logic [3:0] op;
    op = w[POS_OP_HI:POS_OP_LO];
    if (w[POS_GRP_HI:POS_GRP_LO] == GRP_BIT) begin
      f_names_file = 1'b1;
    end else if (w[POS_GRP_HI:POS_GRP_LO] == GRP_BYTE) begin
      // control words and clear-accumulator share the byte group but name no file
      f_names_file = w[POS_DEST] || (op != OP_CTRL && op != OP_CLR);
    end else begin
      f_names_file = 1'b0;
    end
  endfunction

  function automatic logic f_is_skip(input logic [INSTR_W-1:0] w);
    logic [3:0] op;
    op = w[POS_OP_HI:POS_OP_LO];
    unique case (w[POS_GRP_HI:POS_GRP_LO])
      GRP_BYTE: f_is_skip = (op == OP_DECSZ) || (op == OP_INCSZ);
      GRP_BIT:  f_is_skip = w[POS_BITTEST];
      GRP_JUMP: f_is_skip = 1'b0;
      GRP_LIT:  f_is_skip = 1'b0;
    endcase
  endfunction

  function automatic logic f_is_branch(input logic [INSTR_W-1:0] w);
    unique case (w[POS_GRP_HI:POS_GRP_LO])
      GRP_BYTE: f_is_branch = (w[POS_OP_HI:POS_OP_LO] == OP_CTRL) &&
                              (w[7:0] == CTL_RET || w[7:0] == CTL_RETI);
      GRP_BIT:  f_is_branch = 1'b0;
      GRP_JUMP: f_is_branch = 1'b1;
      GRP_LIT:  f_is_branch = (w[POS_OP_HI:POS_OP_HI-1] == LOP_RET);
    endcase
  endfunction

  // ==========================================
  // instruction latch and sequencing state
  logic [INSTR_W-1:0] instr_next;
  ifd_class_t         class_next;
  logic [FA_W-1:0]    fa_next;
  logic [BS_W-1:0]    bs_next;
  logic [LIT_W-1:0]   lit_next;
  logic               nop_next;
  logic               names_reg;
  logic               names_next;
  logic               skip_reg;
  logic               skip_next;
  logic               branch_reg;
  logic               branch_next;

  always_comb begin
    instr_next  = instr_reg;
    class_next  = class_reg;
    fa_next     = file_addr_reg;
    bs_next     = bit_sel_reg;
    lit_next    = literal_reg;
    nop_next    = nop_cycle_reg;
    names_next  = names_reg;
    skip_next   = skip_reg;
    branch_next = branch_reg;
    if (q4) begin
      instr_next = instr_word;
      unique case (instr_word[POS_GRP_HI:POS_GRP_LO])
        GRP_BYTE: class_next = CLS_BYTE;
        GRP_BIT:  class_next = CLS_BIT;
        GRP_JUMP: class_next = CLS_LIT;
        GRP_LIT:  class_next = CLS_LIT;
      endcase
      fa_next = instr_word[POS_FA_HI:0];
      bs_next = instr_word[POS_BS_HI:POS_BS_LO];
      // short literals drop the don't-care bits above the low byte
      if (instr_word[POS_GRP_HI:POS_GRP_LO] == GRP_JUMP) begin
        lit_next = instr_word[LIT_W-1:0];
      end else begin
        lit_next = {3'h0, instr_word[DATA_W-1:0]};
      end
      // a flushed cycle never triggers a second flush
      nop_next    = !nop_cycle_reg && (branch_reg || (skip_reg && cond_true));
      names_next  = f_names_file(instr_word);
      skip_next   = f_is_skip(instr_word);
      branch_next = f_is_branch(instr_word);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      instr_reg     <= INSTR_RST;
      class_reg     <= CLS_BYTE;
      file_addr_reg <= '0;
      bit_sel_reg   <= '0;
      literal_reg   <= '0;
      nop_cycle_reg <= 1'b1;
      names_reg     <= 1'b0;
      skip_reg      <= 1'b0;
      branch_reg    <= 1'b0;
    end else begin
      instr_reg     <= instr_next;
      class_reg     <= class_next;
      file_addr_reg <= fa_next;
      bit_sel_reg   <= bs_next;
      literal_reg   <= lit_next;
      nop_cycle_reg <= nop_next;
      names_reg     <= names_next;
      skip_reg      <= skip_next;
      branch_reg    <= branch_next;
    end
  end

  assign op_reg   = instr_reg[POS_OP_HI:POS_OP_LO];
  assign dest_reg = instr_reg[POS_DEST];

  // ==========================================
  // read-modify-write strobes
  logic live;
  logic grp_byte;
  logic grp_bit;
  assign live     = !nop_cycle_reg;
  assign grp_byte = instr_reg[POS_GRP_HI:POS_GRP_LO] == GRP_BYTE;
  assign grp_bit  = instr_reg[POS_GRP_HI:POS_GRP_LO] == GRP_BIT;

  assign fetch_req = q4;
  // read happens even for write-only words such as clear-file
  assign file_rd   = live && q2 && names_reg;
  assign file_wr   = live && q4 && names_reg &&
                     ((grp_byte && dest_reg) || (grp_bit && !instr_reg[POS_BITTEST]));
  assign w_wr      = live && q4 && (
                     (grp_byte && !dest_reg && op_reg != OP_CTRL) ||
                     (instr_reg[POS_GRP_HI:POS_GRP_LO] == GRP_LIT));
  assign sleep_req = live && q4 && grp_byte && op_reg == OP_CTRL && instr_reg[7:0] == CTL_SLP;
  assign wdt_clear = live && q4 && grp_byte && op_reg == OP_CTRL && instr_reg[7:0] == CTL_WDT;

  // ==========================================
  // pin sampling for port reads
  logic [DATA_W-1:0] pin_s1_reg;
  logic [DATA_W-1:0] pin_s2_reg;
  logic [DATA_W-1:0] pin_s3_reg;
  logic [DATA_W-1:0] pin_reg;
  logic [DATA_W-1:0] pin_next;
  logic [DATA_W-1:0] rmw_next;

  always_comb begin
    // a bit moves only once the second and third stages agree
    pin_next = ((pin_s2_reg ~^ pin_s3_reg) & pin_s3_reg) |
               ((pin_s2_reg ^ pin_s3_reg) & pin_reg);
    rmw_next = rmw_data_reg;
    if (file_rd) begin
      rmw_next = addr_is_port ? pin_reg : file_rd_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pin_s1_reg   <= DATA_RST;
      pin_s2_reg   <= DATA_RST;
      pin_s3_reg   <= DATA_RST;
      pin_reg      <= DATA_RST;
      rmw_data_reg <= DATA_RST;
    end else begin
      pin_s1_reg   <= port_pins;
      pin_s2_reg   <= pin_s1_reg;
      pin_s3_reg   <= pin_s2_reg;
      pin_reg      <= pin_next;
      rmw_data_reg <= rmw_next;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_quiet_cycle;
    (!file_rd && !file_wr && !w_wr) [*4];
  endsequence
  sequence s_fetch_gap;
    !fetch_req [*3] ##1 fetch_req;
  endsequence

  property p_cycle_len;
    fetch_req |=> s_fetch_gap;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle not four periods");

  property p_skip_nop;
    (q4 && skip_reg && cond_true && live) |=> s_quiet_cycle;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("true skip did not idle");

  property p_branch_nop;
    (q4 && branch_reg && live) |=> nop_cycle_reg [*4];
  endproperty
  a_branch_nop: assert property (p_branch_nop) else $error("branch lacks nop cycle");

  property p_read_first;
    file_wr |-> $past(file_rd, 2);
  endproperty
  a_read_first: assert property (p_read_first) else $error("write without prior read");

  property p_dest;
    (q4 && live && grp_byte && names_reg) |-> (file_wr == dest_reg) && (w_wr == !dest_reg);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select ignored");

  property p_fields;
    q4 |=> (file_addr_reg == $past(instr_word[POS_FA_HI:0])) &&
           (bit_sel_reg == $past(instr_word[POS_BS_HI:POS_BS_LO])) &&
           (instr_reg == $past(instr_word));
  endproperty
  a_fields: assert property (p_fields) else $error("operand fields not latched");

  property p_literal;
    (class_reg == CLS_LIT) |-> (instr_reg[POS_GRP_HI:POS_GRP_LO] == GRP_JUMP) ?
      (literal_reg == instr_reg[LIT_W-1:0]) : (literal_reg == {3'h0, instr_reg[7:0]});
  endproperty
  a_literal: assert property (p_literal) else $error("literal width wrong");

  property p_class;
    class_reg == (grp_byte ? CLS_BYTE : (grp_bit ? CLS_BIT : CLS_LIT));
  endproperty
  a_class: assert property (p_class) else $error("group misclassified");

  property p_port_read;
    (file_rd && addr_is_port) |=> rmw_data_reg == $past(pin_reg);
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read not from pins");
endmodule

// ### bench/ifd_file_model.sv
// register file model answering file reads from the decoder
`timescale 1ns/1ps
module ifd_file_model
  import ifd_pkg::*;
#(
  parameter logic [FA_W-1:0] PORT_ADDR = 7'h06
) (
  input  wire logic              clock,
  input  wire logic              file_rd,
  input  wire logic [FA_W-1:0]   file_addr,
  output logic      [DATA_W-1:0] file_rd_data,
  output logic                   addr_is_port
);
  logic [DATA_W-1:0] junk_reg;
  initial junk_reg = 8'h00;
  // churn outside reads so a late sample never sees stale data
  always @(posedge clock) junk_reg <= junk_reg + 8'h3b;
  assign addr_is_port = (file_addr == PORT_ADDR);
  assign file_rd_data = file_rd ? ({1'b1, file_addr} ^ 8'h5a) : junk_reg;
endmodule

// ### bench/test_instruction_field_decoder.sv
// self-checking bench for the instruction field decoder
`timescale 1ns/1ps
module test_instruction_field_decoder;
  import ifd_pkg::*;
  localparam logic [6:0] PA = 7'h06;
  logic clock = 0, nrst = 0, cond_true = 0, aip, fetch_req, dest_reg, nop_cycle_reg;
  logic file_rd, file_wr, w_wr, sleep_req, wdt_clear;
  logic [13:0] instr_word = 0, instr_reg;
  logic [7:0]  fdat, port_pins = 8'ha5, rmw_data_reg;
  logic [3:0]  op_reg;
  logic [6:0]  file_addr_reg;
  logic [2:0]  bit_sel_reg;
  logic [10:0] literal_reg;
  ifd_class_t  class_reg;
  logic [31:0] rs = 32'h4a3aa1f7;
  logic [13:0] pw = 0;
  // the first cycle after the reset nop executes the idle word 0 live
  logic pc = 0, live = 1;
  logic [7:0]  pp = 8'ha5;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  always #2.5 clock = ~clock;
  ifd_decoder dut (.clock(clock), .nrst(nrst), .instr_word(instr_word), .cond_true(cond_true),
    .addr_is_port(aip), .file_rd_data(fdat), .port_pins(port_pins), .fetch_req(fetch_req),
    .instr_reg(instr_reg), .class_reg(class_reg), .op_reg(op_reg),
    .file_addr_reg(file_addr_reg), .dest_reg(dest_reg), .bit_sel_reg(bit_sel_reg),
    .literal_reg(literal_reg), .nop_cycle_reg(nop_cycle_reg), .file_rd(file_rd),
    .file_wr(file_wr), .w_wr(w_wr), .sleep_req(sleep_req), .wdt_clear(wdt_clear),
    .rmw_data_reg(rmw_data_reg));
  ifd_file_model #(.PORT_ADDR(PA)) mem (.clock(clock), .file_rd(file_rd),
    .file_addr(file_addr_reg), .file_rd_data(fdat), .addr_is_port(aip));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic nf(input logic [13:0] w);
    return w[13:12] == 2'h1 || (w[13:12] == 2'h0 && (w[7] || w[11:9] != 3'h0));
  endfunction
  function automatic logic br(input logic [13:0] w);
    return w[13:12] == 2'h2 || w == {6'h0, CTL_RET} || w == {6'h0, CTL_RETI}
      || (w[13:12] == 2'h3 && w[11:10] == LOP_RET);
  endfunction
  function automatic logic sk(input logic [13:0] w);
    return (w[13:12] == 2'h0 && (w[11:8] == OP_DECSZ || w[11:8] == OP_INCSZ))
      || (w[13:12] == 2'h1 && w[11]);
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // one instruction cycle: send w, check the previous word
  task automatic step(input logic [13:0] w, input logic c, input logic pcheck);
    logic [1:0] g;
    logic [15:0] ec;
    g = pw[13:12];
    ec = g == 2'h0 ? 16'(CLS_BYTE) : g == 2'h1 ? 16'(CLS_BIT) : 16'(CLS_LIT);
    @(posedge clock);
    instr_word <= w;
    cond_true <= pc;
    port_pins <= pp;
    #1 chk("nop", 16'(nop_cycle_reg), 16'(!live));
    if (live) begin
      chk("class", 16'(class_reg), ec);
      chk("dest", 16'(dest_reg), 16'(pw[7]));
      chk("instr", 16'(instr_reg), 16'(pw));
      chk("op", 16'(op_reg), 16'(pw[11:8]));
      chk("addr", 16'(file_addr_reg), 16'(pw[6:0]));
      chk("bitsel", 16'(bit_sel_reg), 16'(pw[9:7]));
      chk("lit", 16'(literal_reg), g == 2'h2 ? 16'(pw[10:0]) : 16'(pw[7:0]));
    end
    @(posedge clock);
    #1 chk("file_rd", 16'(file_rd), 16'(live && nf(pw)));
    chk("fetch_lo", 16'(fetch_req), 16'h0);
    @(posedge clock);
    if (live && nf(pw) && (pw[6:0] != PA || pcheck))
      #1 chk("rmw", 16'(rmw_data_reg), pw[6:0] == PA ? 16'(port_pins)
        : 16'({1'b1, pw[6:0]} ^ 8'h5a));
    @(posedge clock);
    #1 chk("fetch", 16'(fetch_req), 16'h1);
    chk("file_wr", 16'(file_wr), 16'(live && (g == 2'h0 ? pw[7] : g == 2'h1 && !pw[11])));
    chk("w_wr", 16'(w_wr), 16'(live && ((g == 2'h0 && !pw[7] && pw[11:8] != 4'h0)
      || g == 2'h3)));
    chk("sleep", 16'(sleep_req), 16'(live && pw == {6'h0, CTL_SLP}));
    chk("wdt", 16'(wdt_clear), 16'(live && pw == {6'h0, CTL_WDT}));
    live = !(live && (br(pw) || (sk(pw) && pc)));
    pw = w;
    pc = c;
  endtask
  // ==========================================
  // corner words, bit 14 is the skip test result
  logic [14:0] cw [22] = '{15'h0ca5, 15'h4b86, 15'h5406, 15'h0063, 15'h0064, 15'h0100,
    15'h0f86, 15'h5c7f, 15'h30aa, 15'h2fff, 15'h3455, 15'h0008, 15'h0009, 15'h3eff,
    15'h0009, 15'h0000, 15'h00ff, 15'h0180, 15'h1006, 15'h0060, 15'h1f80, 15'h0000};
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1;
    for (int i = 0; i < 8 && !fetch_req; i++) begin
      @(posedge clock);
      #1;
    end
    foreach (cw[i]) step(cw[i][13:0], cw[i][14], 1'b1);
    $display("corner words done");
    for (int n = 0; n < 400; n++) begin
      rs = xs(rs);
      if (n % 4 == 0)
        pp = rs[23:16];
      step(rs[13:0], rs[14], n % 4 != 0);
    end
    $display("random words done");
    conclude();
  end
endmodule
